// ===== rtl/eeprom_host.sv
// Bus master that drives a 16-byte two-wire serial EEPROM
// Function
// - Data changes only while clock is low
// - Start and stop framing every command
// - Ninth clock carries acknowledge per byte
// - Acknowledge stable low through clock high
// - Master withholds acknowledge on last byte
// - Control byte: code, three don't-cares, R/W
// - Last control bit one reads, zero writes
// - Word address follows, low nibble used
// - Stop after data starts write cycle
// - Bus idle before and after writes
// - Poll with start and write control
// - Random read: address, repeated start, read
// - Master acknowledge continues sequential read
module eeprom_host
    import eeprom_host_pkg::*;
#(
    // Device-type code; this value is arbitrary, set it to the part's code
    parameter logic [3:0] DEV_CODE = 4'h5
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire cmd_t cmd_i,
    output logic rsp_valid_o,
    output rsp_t rsp_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic busy_o,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

`include "eeprom_host_map.svh"

    state_t state_q;
    state_t state_d;
    sel_t sel_q;
    sel_t sel_d;
    op_t op_q;
    logic [3:0] addr_q;
    logic [7:0] data_q;
    logic [3:0] left_q;
    logic [7:0] shift_q;
    logic [3:0] bcnt_q;
    logic [1:0] q_q;
    logic [`QTR_W-1:0] qcnt_q;
    logic ok_q;
    logic [7:0] polls_q;
    logic sda_m_q;
    logic sda_s_q;
    line_t line_q;
    line_t plan;
    logic rsp_valid_q;
    rsp_t rsp_q;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic load_send;
    logic nack;
    logic retry;
    logic emit;
    logic finish;

    // Timing and decode terms
    wire logic idle = (state_q == ST_IDLE);
    wire logic tick = ce_i && !idle && (qcnt_q == `QTR_W'(`QTR_CYC - 1));
    wire logic bit_end = tick && (q_q == 2'h3);
    wire logic ack_bit = (bcnt_q == `ACK_BIT);
    wire logic seen_ack = !sda_s_q;
    wire logic start_cmd = ce_i && cmd_valid_i && idle;
    wire logic last_byte = (left_q == 4'h0);
    wire logic poll_again = (op_q == OP_POLL) && (sel_q == SEL_CTRL_W)
                            && (polls_q != `POLL_MAX);

    // Byte to transmit next, picked by the upcoming selector
    wire logic [7:0] ctrl_w = {DEV_CODE, `CTRL_DONT_CARE, `RW_WRITE};
    wire logic [7:0] ctrl_r = {DEV_CODE, `CTRL_DONT_CARE, `RW_READ};
    wire logic [7:0] word_addr = {`ADDR_PAD, addr_q};
    wire logic [7:0] next_byte = (sel_d == SEL_CTRL_W) ? ctrl_w :
                                 (sel_d == SEL_CTRL_R) ? ctrl_r :
                                 (sel_d == SEL_ADDR) ? word_addr : data_q;

    // Data levels for transmit and receive slots
    wire logic tx_bit = ack_bit ? 1'b1 : shift_q[7];
    wire logic rx_bit = ack_bit ? last_byte : 1'b1;

    // Sequencer: decides the next bus action at each bit boundary
    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        load_send = 1'b0;
        nack = 1'b0;
        retry = 1'b0;
        emit = 1'b0;
        finish = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_cmd) begin
                    state_d = ST_START;
                    // Current read needs no address phase
                    sel_d = (cmd_i.op == OP_READ_CUR) ? SEL_CTRL_R : SEL_CTRL_W;
                end
            end
            ST_START: begin
                if (bit_end) begin
                    state_d = ST_SEND;
                    load_send = 1'b1;
                end
            end
            ST_SEND: begin
                if (bit_end && ack_bit) begin
                    if (!seen_ack) begin
                        if (poll_again) begin
                            // Busy memory stays silent, so ask again
                            retry = 1'b1;
                            state_d = ST_START;
                        end else begin
                            nack = 1'b1;
                            state_d = ST_STOP;
                        end
                    end else begin
                        case (sel_q)
                            SEL_CTRL_W: begin
                                if (op_q == OP_POLL) begin
                                    state_d = ST_STOP;
                                end else begin
                                    sel_d = SEL_ADDR;
                                    load_send = 1'b1;
                                end
                            end
                            SEL_ADDR: begin
                                if (op_q == OP_WRITE) begin
                                    sel_d = SEL_DATA;
                                    load_send = 1'b1;
                                end else begin
                                    // Repeated start keeps the new pointer
                                    sel_d = SEL_CTRL_R;
                                    state_d = ST_START;
                                end
                            end
                            SEL_DATA: begin
                                // Exactly one full byte, then stop
                                state_d = ST_STOP;
                            end
                            default: begin
                                state_d = ST_RECV;
                            end
                        endcase
                    end
                end
            end
            ST_RECV: begin
                if (bit_end && ack_bit) begin
                    emit = 1'b1;
                    if (last_byte) begin
                        state_d = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (bit_end) begin
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                if (bit_end) begin
                    state_d = ST_IDLE;
                    finish = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Line plan per quarter; quarter 0 holds data so it never moves with SCL
    always_comb begin
        plan.scl = 1'b1;
        plan.sda = 1'b1;
        case (state_q)
            ST_START: begin
                plan.scl = q_q[1];
                plan.sda = (q_q == 2'h0) ? line_q.sda : (q_q != 2'h3);
            end
            ST_SEND: begin
                plan.scl = q_q[1];
                plan.sda = (q_q == 2'h0) ? line_q.sda : tx_bit;
            end
            ST_RECV: begin
                plan.scl = q_q[1];
                plan.sda = (q_q == 2'h0) ? line_q.sda : rx_bit;
            end
            ST_STOP: begin
                plan.scl = q_q[1];
                plan.sda = (q_q == 2'h0) ? line_q.sda : (q_q == 2'h3);
            end
            default: begin
                // Idle and gap leave both lines released
                plan.scl = 1'b1;
                plan.sda = 1'b1;
            end
        endcase
    end

    // SDA synchroniser; only the second stage is read by logic
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else if (ce_i) begin
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Quarter timer; parked while idle so each command starts cleanly
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            qcnt_q <= '0;
            q_q <= 2'h0;
        end else if (ce_i) begin
            if (idle || tick) begin
                qcnt_q <= '0;
            end else begin
                qcnt_q <= qcnt_q + `QTR_W'(1);
            end
            if (idle) begin
                q_q <= 2'h0;
            end else if (tick) begin
                q_q <= q_q + 2'h1;
            end
        end
    end

    // State and byte selector
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            sel_q <= SEL_CTRL_W;
        end else if (ce_i) begin
            state_q <= state_d;
            sel_q <= sel_d;
        end
    end

    // Command capture at acceptance
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            op_q <= OP_WRITE;
            addr_q <= 4'h0;
            data_q <= 8'h00;
        end else if (start_cmd) begin
            op_q <= cmd_i.op;
            addr_q <= cmd_i.addr;
            data_q <= cmd_i.data;
        end
    end

    // Bytes still to read after the current one
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            left_q <= 4'h0;
        end else if (start_cmd) begin
            left_q <= cmd_i.count;
        end else if (ce_i && emit && !last_byte) begin
            left_q <= left_q - 4'h1;
        end
    end

    // Shift register and bit counter for the current byte slot
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            shift_q <= 8'h00;
            bcnt_q <= 4'h0;
        end else if (ce_i) begin
            if (load_send) begin
                shift_q <= next_byte;
                bcnt_q <= 4'h0;
            end else if (bit_end && (state_q == ST_RECV || state_q == ST_SEND)) begin
                if (ack_bit) begin
                    bcnt_q <= 4'h0;
                end else begin
                    bcnt_q <= bcnt_q + 4'h1;
                    // Sample at the end of the high phase
                    if (state_q == ST_RECV) begin
                        shift_q <= {shift_q[6:0], sda_s_q};
                    end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // Outcome tracking: a refused byte fails the command, unless it is a poll's control byte and polls_q is below POLL_MAX
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ok_q <= 1'b0;
            polls_q <= 8'h00;
        end else if (start_cmd) begin
            ok_q <= 1'b1;
            polls_q <= 8'h00;
        end else if (ce_i) begin
            if (nack) begin
                ok_q <= 1'b0;
            end
            if (retry) begin
                polls_q <= polls_q + 8'h01;
            end
        end
    end

    // Result and read-data pulses
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else if (ce_i) begin
            rsp_valid_q <= finish;
            rd_valid_q <= emit;
            if (finish) begin
                rsp_q <= '{ok: ok_q, polls: polls_q};
            end
            if (emit) begin
                rd_data_q <= shift_q;
            end
        end
    end

    // Registered line levels; released lines float high by pull-up
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            line_q <= '{scl: 1'b1, sda: 1'b1};
        end else if (ce_i) begin
            line_q <= plan;
        end
    end

    // Open-drain pins: drive low only, never high
    assign scl_o = 1'b0;
    assign scl_oe_o = !line_q.scl;
    assign sda_o = 1'b0;
    assign sda_oe_o = !line_q.sda;
    assign cmd_ready_o = idle;
    assign busy_o = !idle;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o = rsp_q;
    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;

endmodule

// ===== rtl/eeprom_host_map.svh
// Timing and field constants for the two-wire EEPROM bus master
`ifndef EEPROM_HOST_MAP_SVH
`define EEPROM_HOST_MAP_SVH

// System clock period in ns (50 MHz)
`define CLK_PERIOD_NS 20

// Least SCL half period in ns; each half is split into two quarters
`define SCL_HALF_NS 5000

// Cycles per quarter bit, least time rounded up
`define QTR_CYC ((`SCL_HALF_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Width of the quarter counter
`define QTR_W 8

// Control byte fields
`define CTRL_DONT_CARE 3'h0
`define RW_READ 1'b1
`define RW_WRITE 1'b0

// Upper word-address nibble sent as zero, the memory ignores it
`define ADDR_PAD 4'h0

// Index of the acknowledge bit within a byte slot
`define ACK_BIT 4'h8

// Largest number of unanswered polls before giving up
`define POLL_MAX 8'hff

`endif

// ===== rtl/eeprom_host_pkg.sv
// Types shared by the two-wire EEPROM bus master
package eeprom_host_pkg;

    // Operations the user may request
    typedef enum logic [1:0] {
        OP_WRITE     = 2'h0,
        OP_READ_CUR  = 2'h1,
        OP_READ_RAND = 2'h2,
        OP_POLL      = 2'h3
    } op_t;

    // Bus sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_SEND  = 6'h04,
        ST_RECV  = 6'h08,
        ST_STOP  = 6'h10,
        ST_GAP   = 6'h20
    } state_t;

    // Which byte is being sent
    typedef enum logic [1:0] {
        SEL_CTRL_W = 2'h0,
        SEL_ADDR   = 2'h1,
        SEL_DATA   = 2'h2,
        SEL_CTRL_R = 2'h3
    } sel_t;

    // Command from the user; count is extra bytes for reads
    typedef struct packed {
        op_t op;
        logic [3:0] addr;
        logic [7:0] data;
        logic [3:0] count;
    } cmd_t;

    // Result of one command
    typedef struct packed {
        logic ok;
        logic [7:0] polls;
    } rsp_t;

    // Line levels, 1 = released high
    typedef struct packed {
        logic scl;
        logic sda;
    } line_t;

endpackage

// ===== bench/eeprom_host_properties.sv
// Concurrent checks on the ports of the EEPROM bus master
module eeprom_host_properties
    import eeprom_host_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = 4'h5
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire cmd_t cmd_i,
    input wire logic rsp_valid_o,
    input wire rsp_t rsp_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic busy_o,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // Command taken by the handshake
    sequence s_take;
        cmd_valid_i && cmd_ready_o && ce_i;
    endsequence
    // Both lines released to the pull-ups
    sequence s_free;
        !scl_oe_o && !sda_oe_o;
    endsequence
    chk_idle_free: assert property (!busy_o |-> s_free)
        else $error("bus held while idle");
    chk_ready_idle: assert property (cmd_ready_o != busy_o)
        else $error("ready and busy disagree");
    chk_take_busy: assert property (s_take |=> busy_o && !cmd_ready_o)
        else $error("taken command left master idle");
    chk_start_high: assert property (s_take |=> !sda_oe_o [*8])
        else $error("data pulled before start");
    chk_scl_high: assert property ($fell(scl_oe_o) |-> ##249 !scl_oe_o)
        else $error("clock high phase too short");
    chk_rsp_once: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response pulse too long");
    chk_rsp_free: assert property (rsp_valid_o |-> cmd_ready_o ##0 s_free)
        else $error("response before bus freed");
    chk_rd_pulse: assert property (rd_valid_o |-> busy_o ##1 !rd_valid_o)
        else $error("read pulse out of place");
    chk_drain_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("line driven high");
endmodule

bind eeprom_host eeprom_host_properties #(.DEV_CODE(DEV_CODE)) props (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

// ===== bench/eeprom_model.sv
// Behavioural two-wire EEPROM answering the bus master
module eeprom_model #(
    parameter logic [3:0] CODE = 4'h6, // Arbitrary device-type code
    parameter int WR_CYC = 12000
) (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [7:0] sh, wdata;
    logic [3:0] ptr = 4'h0;
    logic [3:0] nxt;
    logic fresh = 1'b0;
    logic got = 1'b0;
    logic ack_m = 1'b0;
    logic ps = 1'b1;
    logic pd = 1'b1;
    int bitn = 0;
    int st = 0;
    int cyc = 0;
    int busy_end = 0;
    // Known preload so reads can be predicted
    initial begin
        sda_oe_o = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
    end
    // Time base for the internal write cycle
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end
    // One process watches both lines so edges are seen in order
    always @(scl_i, sda_i) begin
        if (scl_i && ps && pd && !sda_i) begin
            st = 1;
            bitn = -1;
            got = 1'b0;
            sda_oe_o = 1'b0;
        end else if (scl_i && ps && !pd && sda_i) begin
            if (st == 3 && got && bitn == 0) begin
                mem[ptr] = wdata;
                fresh = 1'b0;
                busy_end = cyc + WR_CYC;
            end
            st = 0;
            sda_oe_o = 1'b0;
        end else if (scl_i && !ps && st != 0) begin
            if (bitn < 8 && st != 4) sh = {sh[6:0], sda_i};
            if (bitn == 8 && st == 4) ack_m = !sda_i;
        end else if (!scl_i && ps && st != 0) begin
            bitn++;
            if (bitn == 8) begin
                if (st == 4) begin
                    sda_oe_o = 1'b0;
                end else if (st == 1) begin
                    if (sh[7:4] == CODE && cyc >= busy_end) begin
                        sda_oe_o = 1'b1;
                        st = sh[0] ? 5 : 2;
                    end else begin
                        st = 0;
                    end
                end else begin
                    sda_oe_o = 1'b1;
                    if (st == 2) begin
                        ptr = sh[3:0];
                        fresh = 1'b1;
                        st = 3;
                    end else begin
                        wdata = sh;
                        got = 1'b1;
                    end
                end
            end else if (bitn == 9) begin
                bitn = 0;
                sda_oe_o = 1'b0;
                if (st == 5 || (st == 4 && ack_m)) begin
                    nxt = fresh ? ptr : ptr + 4'h1;
                    ptr = nxt;
                    fresh = 1'b0;
                    sh = mem[nxt];
                    st = 4;
                end else if (st == 4) begin
                    st = 0;
                end
            end
            if (st == 4 && bitn < 8) sda_oe_o = !sh[7 - bitn];
        end
        ps = scl_i;
        pd = sda_i;
    end
endmodule

// ===== bench/eeprom_host_test.sv
// Self-checking bench for the EEPROM bus master
`define CHK(name, exp, got) \
    begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end

module eeprom_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_host_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    logic ce = 1'b1;
    cmd_t cmd = '0;
    logic ready, rsp_valid, rd_valid, busy, scl_oe, sda_oe, mem_oe;
    rsp_t rsp;
    logic [7:0] rd_data;
    logic [7:0] got_q[$];
    int fails = 0;
    int check_count = 0;
    // Open-drain wires with pull-ups
    wire sda = ~(sda_oe | mem_oe);
    wire scl = ~scl_oe;

    eeprom_host #(.DEV_CODE(4'h6)) uut (
        .ref_clk_i(clk), .resetn_i(rst_n), .ce_i(ce), .cmd_valid_i(valid),
        .cmd_ready_o(ready), .cmd_i(cmd), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .busy_o(busy), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe)
    );
    eeprom_model #(.CODE(4'h6), .WR_CYC(12000)) mem_dev (
        .clk_i(clk), .scl_i(scl), .sda_i(sda), .sda_oe_o(mem_oe)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    // Issue one command and collect read bytes until the response
    task automatic do_cmd(input op_t op, input logic [3:0] a, input logic [7:0] d,
            input logic [3:0] n);
        int t;
        got_q.delete();
        @(negedge clk);
        cmd = '{op, a, d, n};
        valid = 1'b1;
        t = 0;
        while (ready !== 1'b1 && t < 100) begin
            @(negedge clk);
            t++;
        end
        // A handshake that never completes counts as a mismatch
        if (t >= 100) fails++;
        @(negedge clk);
        valid = 1'b0;
        t = 0;
        while (rsp_valid !== 1'b1 && t < 40000) begin
            @(negedge clk);
            if (rd_valid === 1'b1) got_q.push_back(rd_data);
            t++;
        end
        // A command that never answers counts as a mismatch
        if (t >= 40000) fails++;
    endtask

    // Byte write to the top location
    task automatic test_write();
        do_cmd(OP_WRITE, 4'hf, 8'h5a, 4'h0);
        `CHK("write ok", 1'b1, rsp.ok)
    endtask

    // Read while the memory programs: control byte refused, command fails
    task automatic test_busy_nack();
        do_cmd(OP_READ_CUR, 4'h0, 8'h00, 4'h0);
        `CHK("busy nack", 1'b0, rsp.ok)
        `CHK("busy bytes", 0, got_q.size())
    endtask

    // Poll soon after, while the memory is still programming
    task automatic test_poll();
        do_cmd(OP_POLL, 4'h0, 8'h00, 4'h0);
        `CHK("poll ok", 1'b1, rsp.ok)
        `CHK("poll waited", 1'b1, rsp.polls != 8'h00)
    endtask

    // Random read at 14, running on through the wrap to zero
    task automatic test_seq_read();
        do_cmd(OP_READ_RAND, 4'he, 8'h00, 4'h2);
        `CHK("seq ok", 1'b1, rsp.ok)
        `CHK("seq count", 3, got_q.size())
        if (got_q.size() == 3) begin
            `CHK("seq byte0", 8'h1e, got_q[0])
            `CHK("seq byte1", 8'h5a, got_q[1])
            `CHK("seq byte2", 8'h10, got_q[2])
        end
    endtask

    // Current read continues after the last location read
    task automatic test_cur_read();
        // A frozen master must not take a command
        @(negedge clk);
        ce = 1'b0;
        cmd = '{OP_READ_CUR, 4'h0, 8'h00, 4'h0};
        valid = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("frozen idle", 1'b0, busy)
        valid = 1'b0;
        ce = 1'b1;
        do_cmd(OP_READ_CUR, 4'h0, 8'h00, 4'h0);
        `CHK("cur ok", 1'b1, rsp.ok)
        `CHK("cur byte", 8'h11, got_q.size() == 1 ? got_q[0] : 8'hxx)
    endtask

    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence after eight cycles of reset
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        test_write();
        test_busy_nack();
        test_poll();
        test_seq_read();
        test_cur_read();
        close_out();
    end

    // Watchdog: the traffic needs roughly 72k cycles
    initial begin
        #2_000_000;
        fails++;
        close_out();
    end
endmodule
